// File: adcsel_pkg.sv
package adcsel_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CONV   = 8'h00;
   localparam logic [7:0] OFF_SRC    = 8'h04;
   localparam logic [7:0] OFF_AMP    = 8'h08;
   localparam logic [7:0] OFF_BG     = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   // reset values and writable masks
   localparam logic [7:0] RST_CONV   = 8'h00;
   localparam logic [7:0] RST_SRC    = 8'h00;
   localparam logic [7:0] RST_AMP    = 8'h00;
   localparam logic [7:0] RST_BG     = 8'h00;
   localparam logic [7:0] MASK_CONV  = 8'hBF;
   localparam logic [7:0] MASK_SRC   = 8'hF7;
   localparam logic [7:0] MASK_AMP   = 8'h9F;
   localparam logic [7:0] MASK_BG    = 8'h01;
   // field positions
   localparam int BIT_START  = 7;
   localparam int BIT_BUSY   = 6;
   localparam int BIT_ENABLE = 5;
   localparam int BIT_FORMAT = 4;
   localparam int CH_HI      = 3;
   localparam int CH_LO      = 0;
   localparam int SRC_HI     = 7;
   localparam int SRC_LO     = 4;
   localparam int DIV_HI     = 2;
   localparam int DIV_LO     = 0;
   localparam int BIT_AMP_EN = 7;
   localparam int BIT_AMP_IN = 4;
   localparam int REF_HI     = 3;
   localparam int REF_LO     = 2;
   localparam int GAIN_HI    = 1;
   localparam int GAIN_LO    = 0;
   localparam int BIT_BG_EN  = 0;
   // input source codes
   localparam logic [3:0] SRC_EXT_A     = 4'h0;
   localparam logic [3:0] SRC_AVDD      = 4'h1;
   localparam logic [3:0] SRC_AVDD_2    = 4'h2;
   localparam logic [3:0] SRC_AVDD_4    = 4'h3;
   localparam logic [3:0] SRC_EXT_B     = 4'h4;
   localparam logic [3:0] SRC_AMP       = 4'h5;
   localparam logic [3:0] SRC_AMP_2     = 4'h6;
   localparam logic [3:0] SRC_AMP_4     = 4'h7;
   localparam logic [1:0] SRC_TOP_GND   = 2'h2;
   localparam logic [1:0] SRC_TOP_EXT   = 2'h3;
   // reference codes
   localparam logic [1:0] REF_SUPPLY    = 2'h0;
   localparam logic [1:0] REF_EXT_PIN   = 2'h1;
   // channel counts of the two variants, switch count and divider counter width
   localparam logic [3:0] CH_COUNT_FULL = 4'hC;
   localparam logic [3:0] CH_COUNT_LITE = 4'h9;
   localparam int         CH_NUM        = 12;
   localparam int         DIV_W         = 7;
   // ahb constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [1:0] {
      GAIN_1     = 2'b00,
      GAIN_1P667 = 2'b01,
      GAIN_2P5   = 2'b10,
      GAIN_3P333 = 2'b11
   } adcsel_gain_t;

   typedef struct packed {
      logic ext_on;
      logic avdd_full;
      logic avdd_half;
      logic avdd_quarter;
      logic amp_full;
      logic amp_half;
      logic amp_quarter;
      logic ground;
   } adcsel_inmux_t;

   typedef struct packed {
      logic supply;
      logic ext_pin;
      logic amp_out;
   } adcsel_refmux_t;

   typedef struct packed {
      logic         enable;
      logic         bandgap_in;
      logic         ref_pin_on;
      adcsel_gain_t gain;
   } adcsel_amp_t;
endpackage : adcsel_pkg

// File: adcsel_top.sv
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module adcsel_top #(
   parameter logic TWELVE_CHANNELS = 1'b1
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic                       hready,
   input  wire logic [31:0]                hwdata,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   input  wire logic                       conv_done,
   input  wire logic [11:0]                conv_result,
   output logic                            conv_start,
   output logic                            converter_enable,
   output logic                            conv_clock_en,
   output logic      [11:0]                analog_channel_input,
   output adcsel_pkg::adcsel_inmux_t       in_mux,
   output adcsel_pkg::adcsel_refmux_t      ref_mux,
   output adcsel_pkg::adcsel_amp_t         gain_amplifier,
   output logic                            bandgap_enable,
   output logic      [7:0]                 result_high_byte,
   output logic      [7:0]                 result_low_byte
);
   localparam logic [3:0] CH_LIMIT = TWELVE_CHANNELS ? adcsel_pkg::CH_COUNT_FULL
                                                     : adcsel_pkg::CH_COUNT_LITE;

   logic [7:0]                  conv_reg_ff;
   logic [7:0]                  src_reg_ff;
   logic [7:0]                  amp_reg_ff;
   logic [7:0]                  bg_reg_ff;
   logic                        busy_ff;
   logic                        start_prev_ff;
   logic                        conv_start_ff;
   logic                        wr_pend_ff;
   logic [7:0]                  addr_ff;
   logic [31:0]                 hrdata_ff;
   logic [7:0]                  high_ff;
   logic [7:0]                  low_ff;
   logic [adcsel_pkg::DIV_W-1:0] div_cnt_ff;
   logic [2:0]                  div_sel_ff;
   logic                        clk_en_ff;
   logic [11:0]                 ch_ff;
   adcsel_pkg::adcsel_inmux_t   in_mux_ff;
   adcsel_pkg::adcsel_refmux_t  ref_mux_ff;
   adcsel_pkg::adcsel_amp_t     amp_ff;

   logic                        addr_phase;
   logic [7:0]                  wbyte;
   logic [7:0]                  rd_byte;
   logic [31:0]                 nxt_hrdata;
   logic                        nxt_start;
   logic [3:0]                  src;
   logic [3:0]                  ch_code;
   logic [2:0]                  div_sel;
   logic [7:0]                  period;
   logic [adcsel_pkg::DIV_W-1:0] div_last;
   logic                        src_ext;
   adcsel_pkg::adcsel_inmux_t   nxt_in_mux;
   adcsel_pkg::adcsel_refmux_t  nxt_ref_mux;
   adcsel_pkg::adcsel_amp_t     nxt_amp;
   logic [11:0]                 nxt_ch;

   // bus slave: zero wait states, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = adcsel_pkg::HRESP_OKAY;
   assign hrdata     = hrdata_ff;
   assign addr_phase = hsel && hready && htrans[1];
   assign wbyte      = hwdata[7:0];

   // only low address byte decoded, so the map aliases every 256 bytes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end else begin
         wr_pend_ff <= addr_phase && hwrite && (hsize == adcsel_pkg::HSIZE_WORD);
         if (addr_phase) begin
            addr_ff <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_reg_ff <= adcsel_pkg::RST_CONV;
         src_reg_ff  <= adcsel_pkg::RST_SRC;
         amp_reg_ff  <= adcsel_pkg::RST_AMP;
         bg_reg_ff   <= adcsel_pkg::RST_BG;
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            adcsel_pkg::OFF_CONV: conv_reg_ff <= wbyte & adcsel_pkg::MASK_CONV;
            adcsel_pkg::OFF_SRC:  src_reg_ff  <= wbyte & adcsel_pkg::MASK_SRC;
            adcsel_pkg::OFF_AMP:  amp_reg_ff  <= wbyte & adcsel_pkg::MASK_AMP;
            adcsel_pkg::OFF_BG:   bg_reg_ff   <= wbyte & adcsel_pkg::MASK_BG;
            default: ;
         endcase
      end
   end

   // read data is latched in the address phase; a read pipelined straight
   // behind a write to the same register returns the old value
   always_comb begin
      rd_byte    = 8'h00;
      nxt_hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
         adcsel_pkg::OFF_CONV: begin
            rd_byte = conv_reg_ff;
            rd_byte[adcsel_pkg::BIT_BUSY] = busy_ff;
         end
         adcsel_pkg::OFF_SRC: rd_byte = src_reg_ff & adcsel_pkg::MASK_SRC;
         adcsel_pkg::OFF_AMP: rd_byte = amp_reg_ff & adcsel_pkg::MASK_AMP;
         adcsel_pkg::OFF_BG:  rd_byte = bg_reg_ff & adcsel_pkg::MASK_BG;
         default: rd_byte = 8'h00;
      endcase
      if (haddr[7:0] == adcsel_pkg::OFF_RESULT) begin
         nxt_hrdata = {16'h0000, high_ff, low_ff};
      end else begin
         nxt_hrdata = {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   // conversion start on the falling edge of a raised start bit
   assign converter_enable = conv_reg_ff[adcsel_pkg::BIT_ENABLE];
   assign nxt_start = start_prev_ff && !conv_reg_ff[adcsel_pkg::BIT_START]
                      && converter_enable;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_prev_ff <= 1'b0;
         conv_start_ff <= 1'b0;
      end else begin
         start_prev_ff <= conv_reg_ff[adcsel_pkg::BIT_START];
         conv_start_ff <= nxt_start;
      end
   end
   assign conv_start = conv_start_ff;

   // a start in the completion cycle wins, so a new conversion is never lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_ff <= 1'b0;
      end else if (nxt_start) begin
         busy_ff <= 1'b1;
      end else if (conv_done) begin
         busy_ff <= 1'b0;
      end
   end

   // result packing; bytes hold while the converter is disabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         high_ff <= 8'h00;
         low_ff  <= 8'h00;
      end else if (conv_done && converter_enable) begin
         if (conv_reg_ff[adcsel_pkg::BIT_FORMAT]) begin
            high_ff <= {4'h0, conv_result[11:8]};
            low_ff  <= conv_result[7:0];
         end else begin
            high_ff <= conv_result[11:4];
            low_ff  <= {conv_result[3:0], 4'h0};
         end
      end
   end
   assign result_high_byte = high_ff;
   assign result_low_byte  = low_ff;

   // conversion clock divider
   assign div_sel  = src_reg_ff[adcsel_pkg::DIV_HI:adcsel_pkg::DIV_LO];
   assign period   = 8'h01 << div_sel;
   assign div_last = adcsel_pkg::DIV_W'(period - 8'h01);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_ff <= '0;
         div_sel_ff <= 3'h0;
         clk_en_ff  <= 1'b0;
      end else begin
         div_sel_ff <= div_sel;
         if (div_sel != div_sel_ff) begin
            div_cnt_ff <= '0;
            clk_en_ff  <= 1'b0;
         end else if (div_cnt_ff == div_last) begin
            div_cnt_ff <= '0;
            clk_en_ff  <= 1'b1;
         end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
            clk_en_ff  <= 1'b0;
         end
      end
   end
   assign conv_clock_en = clk_en_ff;

   // input source decode
   assign src     = src_reg_ff[adcsel_pkg::SRC_HI:adcsel_pkg::SRC_LO];
   assign ch_code = conv_reg_ff[adcsel_pkg::CH_HI:adcsel_pkg::CH_LO];
   assign src_ext = (src == adcsel_pkg::SRC_EXT_A) || (src == adcsel_pkg::SRC_EXT_B)
                    || (src[3:2] == adcsel_pkg::SRC_TOP_EXT);

   always_comb begin
      nxt_in_mux              = '0;
      nxt_in_mux.ext_on       = src_ext;
      nxt_in_mux.avdd_full    = (src == adcsel_pkg::SRC_AVDD);
      nxt_in_mux.avdd_half    = (src == adcsel_pkg::SRC_AVDD_2);
      nxt_in_mux.avdd_quarter = (src == adcsel_pkg::SRC_AVDD_4);
      nxt_in_mux.amp_full     = (src == adcsel_pkg::SRC_AMP);
      nxt_in_mux.amp_half     = (src == adcsel_pkg::SRC_AMP_2);
      nxt_in_mux.amp_quarter  = (src == adcsel_pkg::SRC_AMP_4);
      nxt_in_mux.ground       = (src[3:2] == adcsel_pkg::SRC_TOP_GND);
   end

   // one switch per channel; codes past the variant's count float
   for (genvar i = 0; i < adcsel_pkg::CH_NUM; i++) begin : g_ch
      localparam logic [3:0] IDX = 4'(i);
      assign nxt_ch[i] = src_ext && (ch_code == IDX) && (IDX < CH_LIMIT);
   end

   // reference and amplifier controls
   always_comb begin
      nxt_ref_mux         = '0;
      nxt_ref_mux.supply  = (amp_reg_ff[adcsel_pkg::REF_HI:adcsel_pkg::REF_LO]
                             == adcsel_pkg::REF_SUPPLY);
      nxt_ref_mux.ext_pin = (amp_reg_ff[adcsel_pkg::REF_HI:adcsel_pkg::REF_LO]
                             == adcsel_pkg::REF_EXT_PIN);
      nxt_ref_mux.amp_out = amp_reg_ff[adcsel_pkg::REF_HI];
   end

   // the enable is left to software; forcing it would hide a wrong setup
   always_comb begin
      nxt_amp            = '0;
      nxt_amp.enable     = amp_reg_ff[adcsel_pkg::BIT_AMP_EN];
      nxt_amp.bandgap_in = amp_reg_ff[adcsel_pkg::BIT_AMP_IN];
      nxt_amp.ref_pin_on = !amp_reg_ff[adcsel_pkg::BIT_AMP_IN];
      nxt_amp.gain       = adcsel_pkg::adcsel_gain_t'(
                           amp_reg_ff[adcsel_pkg::GAIN_HI:adcsel_pkg::GAIN_LO]);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ch_ff      <= 12'h000;
         in_mux_ff  <= '0;
         ref_mux_ff <= '0;
         amp_ff     <= '0;
      end else begin
         ch_ff      <= nxt_ch;
         in_mux_ff  <= nxt_in_mux;
         ref_mux_ff <= nxt_ref_mux;
         amp_ff     <= nxt_amp;
      end
   end
   assign analog_channel_input = ch_ff;
   assign in_mux               = in_mux_ff;
   assign ref_mux              = ref_mux_ff;
   assign gain_amplifier       = amp_ff;
   assign bandgap_enable       = bg_reg_ff[adcsel_pkg::BIT_BG_EN];

   // divider spacing monitor, only read by the checks below
   logic [8:0] gap_ff;
   logic       sel_moved_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_ff       <= 9'h000;
         sel_moved_ff <= 1'b1;
      end else begin
         if (clk_en_ff) begin
            gap_ff <= 9'h001;
         end else if (gap_ff != 9'h1FF) begin
            gap_ff <= gap_ff + 9'h001;
         end
         if (div_sel != div_sel_ff) begin
            sel_moved_ff <= 1'b1;
         end else if (clk_en_ff) begin
            sel_moved_ff <= 1'b0;
         end
      end
   end

   AST_DIV_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en_ff && !sel_moved_ff && (div_sel == div_sel_ff)
      |-> gap_ff == {1'b0, period})
      else $error("conversion clock pulse spacing wrong");

   AST_DIV_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
      (div_sel != div_sel_ff) |=> !clk_en_ff && (div_cnt_ff == '0))
      else $error("divider did not restart on select change");

   AST_CH_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
      (ch_code >= CH_LIMIT) && $stable(ch_code) |=> ch_ff == 12'h000)
      else $error("out of range channel code did not float");

   AST_CH_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
      src_ext && (ch_code < CH_LIMIT) |=> $onehot(ch_ff) && in_mux_ff.ext_on)
      else $error("external channel not routed");

   AST_INT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_mux_ff.avdd_full || in_mux_ff.avdd_half || in_mux_ff.avdd_quarter
       || in_mux_ff.amp_full || in_mux_ff.amp_half || in_mux_ff.amp_quarter
       || in_mux_ff.ground) |-> (ch_ff == 12'h000) && !in_mux_ff.ext_on)
      else $error("external channel on with internal source");

   AST_GROUND: assert property (@(posedge hclk) disable iff (!hresetn)
      (src[3:2] == adcsel_pkg::SRC_TOP_GND) |=> in_mux_ff.ground && $onehot(in_mux_ff))
      else $error("ground not selected for 10xx source");

   AST_SUPPLY_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
      (src == adcsel_pkg::SRC_AVDD_4) |=> in_mux_ff.avdd_quarter && $onehot(in_mux_ff))
      else $error("quarter supply not selected");

   AST_AMP_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
      (src == adcsel_pkg::SRC_AMP_2) |=> in_mux_ff.amp_half && $onehot(in_mux_ff))
      else $error("half amplifier output not selected");

   AST_REF_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
      ref_mux_ff.ext_pin |-> !ref_mux_ff.supply && !ref_mux_ff.amp_out)
      else $error("external reference pin on with internal reference");

   AST_BG_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
      gain_amplifier.bandgap_in |-> !gain_amplifier.ref_pin_on)
      else $error("reference input pin on with bandgap input");

   AST_START: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_start_ff |-> $past(start_prev_ff) && !start_prev_ff && $past(converter_enable))
      else $error("conversion start without low-high-low start bit");

   AST_BUSY_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_start_ff |-> busy_ff ##1 (busy_ff || $past(conv_done)))
      else $error("busy not set at conversion start");

   AST_BUSY_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done && !nxt_start |=> !busy_ff)
      else $error("busy not cleared at conversion completion");

   AST_RSVD_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && (haddr[7:0] == adcsel_pkg::OFF_AMP)
      |=> (hrdata_ff & ~{24'h00_0000, adcsel_pkg::MASK_AMP}) == 32'h0000_0000)
      else $error("reserved amplifier register bits read nonzero");

   AST_FORMAT: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done && converter_enable && conv_reg_ff[adcsel_pkg::BIT_FORMAT]
      |=> high_ff[7:4] == 4'h0 && low_ff == $past(conv_result[7:0]))
      else $error("right-justified result packed wrong");

   AST_REF_AMP: assert property (@(posedge hclk) disable iff (!hresetn)
      amp_reg_ff[adcsel_pkg::REF_HI] |=> ref_mux_ff.amp_out && !ref_mux_ff.ext_pin)
      else $error("external reference pin on with amplifier reference");

   AST_DIV_FULL: assert property (@(posedge hclk) disable iff (!hresetn)
      (div_sel == '0) && (div_sel_ff == '0) |=> clk_en_ff)
      else $error("undivided conversion clock missed a pulse");

   AST_START_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !converter_enable |=> !conv_start_ff)
      else $error("conversion started with converter disabled");

   AST_HOLD_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !converter_enable |=> $stable(high_ff) && $stable(low_ff))
      else $error("result bytes changed with converter disabled");

   AST_CH_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
      $onehot0(ch_ff))
      else $error("more than one external channel switched on");

endmodule : adcsel_top

// File: testbench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        conv_done;
   logic [11:0] conv_result;
   logic        conv_start;
   logic        converter_enable;
   logic        conv_clock_en;
   logic [11:0] analog_channel_input;
   adcsel_pkg::adcsel_inmux_t  in_mux;
   adcsel_pkg::adcsel_refmux_t ref_mux;
   adcsel_pkg::adcsel_amp_t    gain_amplifier;
   logic        bandgap_enable;
   logic [7:0]  result_high_byte;
   logic [7:0]  result_low_byte;
   int          fails;
   int          tests_run;
   logic [31:0] rd;
   logic [11:0] ch_lite;
   // bandgap start-up wait in clock cycles, a plain default
   localparam int BG_SETTLE = 16;

   adcsel_top #(.TWELVE_CHANNELS(1'b1)) i_adcsel_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
      .conv_result(conv_result), .conv_start(conv_start),
      .converter_enable(converter_enable), .conv_clock_en(conv_clock_en),
      .analog_channel_input(analog_channel_input), .in_mux(in_mux), .ref_mux(ref_mux),
      .gain_amplifier(gain_amplifier), .bandgap_enable(bandgap_enable),
      .result_high_byte(result_high_byte), .result_low_byte(result_low_byte));

   // nine-channel variant shares the bus; only its channel switches are judged
   adcsel_top #(.TWELVE_CHANNELS(1'b0)) i_adcsel_top_nine (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(), .hreadyout(), .hresp(), .conv_done(conv_done),
      .conv_result(conv_result), .conv_start(), .converter_enable(), .conv_clock_en(),
      .analog_channel_input(ch_lite), .in_mux(), .ref_mux(), .gain_amplifier(),
      .bandgap_enable(), .result_high_byte(), .result_low_byte());

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic final_report;
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // entered right after a rising edge; waits on hready, never on a fixed count
   task automatic ahb(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= adcsel_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= adcsel_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ahb(a, 1'b1, d);
      repeat (2) @(posedge hclk);
   endtask : wr

   function automatic logic [7:0] exp_mux(input logic [3:0] s);
      case (s)
         4'h1: exp_mux = 8'h40;
         4'h2: exp_mux = 8'h20;
         4'h3: exp_mux = 8'h10;
         4'h5: exp_mux = 8'h08;
         4'h6: exp_mux = 8'h04;
         4'h7: exp_mux = 8'h02;
         4'h8, 4'h9, 4'hA, 4'hB: exp_mux = 8'h01;
         default: exp_mux = 8'h80;
      endcase
   endfunction : exp_mux

   task automatic t_reset;
      repeat (3) @(posedge hclk);
      `CHK(in_mux, 8'h80)
      `CHK(analog_channel_input, 12'h001)
      `CHK(ref_mux, 3'h4)
      `CHK(bandgap_enable, 1'b0)
      ahb(8'h04, 1'b0, 8'h00); `CHK(rd, 32'h00000000)
      ahb(8'h08, 1'b0, 8'h00); `CHK(rd, 32'h00000000)
      ahb(8'h0C, 1'b0, 8'h00); `CHK(rd, 32'h00000000)
      ahb(8'h20, 1'b0, 8'h00); `CHK(rd, 32'h00000000)
   endtask : t_reset

   task automatic t_channels;
      for (int c = 0; c < 16; c++) begin
         wr(8'h00, 8'(c));
         `CHK(analog_channel_input, (c < 12) ? 12'(1 << c) : 12'h000)
         `CHK(ch_lite, (c < 9) ? 12'(1 << c) : 12'h000)
      end
   endtask : t_channels

   // channel 2 stays selected so any leak of an external switch shows
   task automatic t_sources;
      wr(8'h00, 8'h02);
      for (int s = 0; s < 16; s++) begin
         wr(8'h04, 8'(s << 4));
         `CHK(in_mux, exp_mux(4'(s)))
         `CHK(analog_channel_input, (exp_mux(4'(s)) == 8'h80) ? 12'h004 : 12'h000)
      end
   endtask : t_sources

   task automatic t_amp;
      logic [7:0] v;
      wr(8'h0C, 8'h01);
      `CHK(bandgap_enable, 1'b1)
      repeat (BG_SETTLE) @(posedge hclk);
      // reference pins count as freed from their shared functions here
      for (int i = 0; i < 4; i++) begin
         v = {i[0], 2'b00, i[1], i[1:0], i[1:0]};
         wr(8'h08, v);
         `CHK(gain_amplifier, {i[0], i[1], ~i[1], i[1:0]})
         `CHK(ref_mux, (i == 0) ? 3'h4 : (i == 1) ? 3'h2 : 3'h1)
         ahb(8'h08, 1'b0, 8'h00); `CHK(rd, {24'h0, v})
      end
      wr(8'h04, 8'hFF); ahb(8'h04, 1'b0, 8'h00); `CHK(rd, 32'h000000F7)
      wr(8'h08, 8'hFF); ahb(8'h08, 1'b0, 8'h00); `CHK(rd, 32'h0000009F)
      wr(8'h0C, 8'hFF); ahb(8'h0C, 1'b0, 8'h00); `CHK(rd, 32'h00000001)
      `CHK(bandgap_enable, 1'b1)
      wr(8'h0C, 8'h00);
      `CHK(bandgap_enable, 1'b0)
   endtask : t_amp

   task automatic t_divider;
      int codes[5] = '{0, 1, 2, 3, 7};
      int n;
      foreach (codes[k]) begin
         wr(8'h04, 8'(codes[k]));
         repeat ((1 << codes[k]) + 4) @(posedge hclk);
         n = 0;
         repeat (256) begin
            @(posedge hclk);
            if (conv_clock_en === 1'b1) n++;
         end
         `CHK(n, 256 >> codes[k])
      end
   endtask : t_divider

   // start toggled with the converter off must not start anything
   task automatic t_start_off;
      wr(8'h00, 8'h80);
      wr(8'h00, 8'h00);
      `CHK(conv_start, 1'b0)
      ahb(8'h00, 1'b0, 8'h00); `CHK(rd, 32'h00000000)
   endtask : t_start_off

   task automatic t_conv(input logic fmt, input logic [11:0] r);
      int n;
      wr(8'h00, {3'b101, fmt, 4'h0});
      `CHK(converter_enable, 1'b1)
      ahb(8'h00, 1'b1, {3'b001, fmt, 4'h0});
      n = 0;
      while (conv_start !== 1'b1 && n < 8) begin
         @(posedge hclk);
         n++;
      end
      `CHK(conv_start, 1'b1)
      ahb(8'h00, 1'b0, 8'h00); `CHK(rd, {24'h0, 3'b011, fmt, 4'h0})
      conv_done   <= 1'b1;
      conv_result <= r;
      @(posedge hclk);
      conv_done   <= 1'b0;
      @(posedge hclk);
      ahb(8'h10, 1'b0, 8'h00);
      `CHK(rd, fmt ? {20'h0, r} : {16'h0, r, 4'h0})
      `CHK({result_high_byte, result_low_byte}, fmt ? {4'h0, r} : {r, 4'h0})
      ahb(8'h00, 1'b0, 8'h00); `CHK(rd[6], 1'b0)
   endtask : t_conv

   initial begin
      fails = 0; tests_run = 0;
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; conv_done = 1'b0; conv_result = 12'h000;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_channels();
      t_sources();
      t_amp();
      t_divider();
      t_start_off();
      t_conv(1'b1, 12'hA5C);
      t_conv(1'b0, 12'h3E7);
      final_report();
   end

   // the whole sequence needs well under 5000 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      final_report();
   end
endmodule : testbench
